// ### verilog/ccr_ctrl.v
// cpu control register group: status word, pc, local base, stack pointer
`timescale 1ns/1ps
`default_nettype none
`include "ccr_regs.vh"
module ccr_ctrl (
   input  wire        clk_sys,
   input  wire        rst,
   // any reset source: pin, break op, watchdog, opcode trap
   input  wire        reset_event,
   // arithmetic / logic results from execution
   input  wire        alu_valid,
   input  wire        alu_is_logic,
   input  wire        alu_sub,
   input  wire [15:0] alu_a,
   input  wire [15:0] alu_b,
   // accumulator load
   input  wire        acc_load,
   input  wire        acc_load_word,
   input  wire [15:0] acc_load_data,
   // bit test
   input  wire        bit_test,
   input  wire        bit_value,
   // width ops
   input  wire        set_width_op,
   input  wire        clear_width_op,
   // carry set/clear instruction
   input  wire        carry_wr,
   input  wire        carry_val,
   // instruction completes; pc advance
   input  wire        instr_done,
   input  wire [2:0]  instr_len,
   input  wire        pc_load,
   input  wire [15:0] pc_load_val,
   // interrupt sequencing
   input  wire        irq_enter,
   input  wire        irq_maskable,
   input  wire [15:0] vector_val,
   input  wire        return_from_interrupt,
   input  wire [15:0] restore_sw,
   // stack traffic from calls/pushes/returns/pops
   input  wire        stack_push,
   input  wire        stack_pop,
   // special register port
   input  wire        sfr_wr,
   input  wire        sfr_word,
   input  wire [7:0]  sfr_addr,
   input  wire [15:0] sfr_wdata,
   input  wire        sfr_rd,
   // local/page address request
   input  wire [2:0]  local_index,
   input  wire [5:0]  sba_offset,
   output reg  [15:0] sfr_rdata,
   output reg         sfr_hit,
   output reg  [15:0] status_word,
   output reg  [15:0] pc,
   output reg  [15:0] hw_stack_pointer,
   output reg  [15:0] stack_addr,
   output reg  [15:0] push_data,
   output reg  [15:0] local_addr,
   output reg  [15:0] page_bit_addr,
   output reg  [15:0] pointer_set_addr,
   output reg         global_irq_enable,
   output reg         width_descriptor,
   output reg  [15:0] acc_result
);
   // ==========================================================
   // storage
   reg  [7:0]  local_window_select;
   reg  [7:0]  current_page_select;
   reg  [15:0] next_sw;
   wire [15:0] sp_q;
   wire [15:0] sp_addr;
   wire [15:0] alu_res;
   wire        f_cy;
   wire        f_hc;
   wire        f_z;
   wire        f_n;
   wire        f_v;
   wire [15:0] eff_sw;
   wire        sel_sp;
   wire        sel_win;
   wire        sel_sw;
   wire        sp_wr_lo;
   wire        sp_wr_hi;
   wire        dd_now;

   // width seen by an instruction issued in the same cycle as a width change or load
   assign dd_now = set_width_op ? 1'b1 : clear_width_op ? 1'b0 :
                   acc_load ? acc_load_word : status_word[`CCR_BIT_DD];

   ccr_flag_calc u_flags (
      .op_word (dd_now),
      .op_sub  (alu_sub),
      .opnd_a  (alu_a),
      .opnd_b  (alu_b),
      .result  (alu_res),
      .carry   (f_cy),
      .half    (f_hc),
      .zero    (f_z),
      .neg     (f_n),
      .ovf     (f_v)
   );

   // ==========================================================
   // special register decode
   assign sel_sp   = {sfr_addr[7:1], 1'b0} == `CCR_SP_OFS;
   assign sel_win  = {sfr_addr[7:1], 1'b0} == `CCR_WIN_OFS;
   assign sel_sw   = {sfr_addr[7:1], 1'b0} == `CCR_SW_LO_OFS;
   assign sp_wr_lo = sfr_wr && sel_sp && (sfr_word || !sfr_addr[0]);
   assign sp_wr_hi = sfr_wr && sel_sp && (sfr_word || sfr_addr[0]);

   ccr_stack_ptr u_sp (
      .clk_sys    (clk_sys),
      .rst        (rst | reset_event),
      .push       (stack_push | irq_enter),
      .pop        (stack_pop | return_from_interrupt),
      .wr_lo      (sp_wr_lo),
      .wr_hi      (sp_wr_hi),
      .wr_data    (sfr_word ? sfr_wdata : {sfr_wdata[7:0], sfr_wdata[7:0]}),
      .sp         (sp_q),
      .stack_addr (sp_addr)
   );

   // ==========================================================
   // status word next value
   always @* begin
      next_sw = status_word;
      if (alu_valid) begin
         next_sw[`CCR_BIT_NEG] = alu_is_logic ? (dd_now ? alu_a[15] : alu_a[7]) : f_n;
         next_sw[`CCR_BIT_ZF]  = alu_is_logic ? (dd_now ? alu_a == 16'h0000 : alu_a[7:0] == 8'h00) : f_z;
         if (!alu_is_logic) begin
            next_sw[`CCR_BIT_CY] = f_cy;
            next_sw[`CCR_BIT_HC] = f_hc;
            next_sw[`CCR_BIT_OV] = f_v;
         end
      end
      if (acc_load) begin
         next_sw[`CCR_BIT_DD] = acc_load_word;
         next_sw[`CCR_BIT_ZF] = acc_load_word ? acc_load_data == 16'h0000 :
                                acc_load_data[7:0] == 8'h00;
      end
      if (bit_test)
         next_sw[`CCR_BIT_ZF] = ~bit_value;
      if (set_width_op)
         next_sw[`CCR_BIT_DD] = 1'b1;
      if (clear_width_op)
         next_sw[`CCR_BIT_DD] = 1'b0;
      if (carry_wr)
         next_sw[`CCR_BIT_CY] = carry_val;
      // explicit writes override computed flags; user bits change only here and on return from interrupt
      if (sfr_wr && sel_sw) begin
         if (sfr_word || !sfr_addr[0])
            next_sw[7:0] = sfr_wdata[7:0];
         if (sfr_word)
            next_sw[15:8] = sfr_wdata[15:8];
         else if (sfr_addr[0])
            next_sw[15:8] = sfr_wdata[7:0];
      end
      if (return_from_interrupt)
         next_sw = restore_sw;
      if (irq_enter && irq_maskable)
         next_sw[`CCR_BIT_IE] = 1'b0;
   end

   // ==========================================================
   // registers
   always @(posedge clk_sys) begin
      if (rst || reset_event) begin
         status_word       <= `CCR_SW_RST;
         pc                <= vector_val;
         push_data         <= 16'h0000;
         global_irq_enable <= 1'b0;
         width_descriptor  <= 1'b0;
         acc_result        <= 16'h0000;
      end else begin
         status_word       <= next_sw;
         // enable registered: sequencer sees it from the next instruction
         global_irq_enable <= next_sw[`CCR_BIT_IE];
         width_descriptor  <= next_sw[`CCR_BIT_DD];
         if (alu_valid)
            acc_result <= alu_res;
         // pushed image is the pre-interrupt value, enable still set
         if (irq_enter)
            push_data <= status_word;
         if (irq_enter)
            pc <= vector_val;
         else if (pc_load)
            pc <= pc_load_val;
         else if (instr_done)
            pc <= pc + {13'h0000, instr_len};
      end
   end

   // local base bytes have no reset value
   always @(posedge clk_sys) begin
      if (sfr_wr && sel_win) begin
         if (sfr_word || !sfr_addr[0])
            local_window_select <= sfr_wdata[7:0];
         if (sfr_word)
            current_page_select <= sfr_wdata[15:8];
         else if (sfr_addr[0])
            current_page_select <= sfr_wdata[7:0];
      end
   end

   // ==========================================================
   // addresses and readback
   always @(posedge clk_sys) begin
      if (rst) begin
         hw_stack_pointer <= `CCR_SP_RST;
         stack_addr       <= 16'hFFFE;
         local_addr       <= `CCR_LOCAL_BASE;
         page_bit_addr    <= {8'h00, `CCR_SBA_OFS};
         pointer_set_addr <= `CCR_PSET_BASE;
         sfr_rdata        <= 16'h0000;
         sfr_hit          <= 1'b0;
      end else begin
         hw_stack_pointer <= sp_q;
         stack_addr       <= sp_addr;
         local_addr       <= `CCR_LOCAL_BASE + {5'h00, local_window_select, 3'h0}
                             + {13'h0000, local_index};
         page_bit_addr    <= {current_page_select, `CCR_SBA_OFS | {2'b00, sba_offset}};
         pointer_set_addr <= `CCR_PSET_BASE + {10'h000, status_word[2:0], 3'h0};
         sfr_hit          <= sfr_rd && (sel_sp || sel_win || sel_sw);
         if (!sfr_rd)
            sfr_rdata <= 16'h0000;
         else if (sel_sp)
            sfr_rdata <= sfr_word ? sp_q : {8'h00, sfr_addr[0] ? sp_q[15:8] : sp_q[7:0]};
         else if (sel_win)
            sfr_rdata <= sfr_word ? {current_page_select, local_window_select} :
                         {8'h00, sfr_addr[0] ? current_page_select : local_window_select};
         else if (sel_sw)
            sfr_rdata <= sfr_word ? status_word :
                         {8'h00, sfr_addr[0] ? status_word[15:8] : status_word[7:0]};
         else
            sfr_rdata <= 16'h0000;
      end
   end
endmodule
`default_nettype wire

// ### verilog/ccr_regs.vh
// constants for the cpu control register group
// ==========================================================
// How it works
// - any reset source clears the whole status word to zero.
// - carry flag bit 15 from bit 7 or bit 15 carry/borrow.
// - zero flag bit 14 for zero result, load or tested bit.
// - half carry bit 13 from carry/borrow at bit 3.
// - width descriptor bit 12 selects word (1) or byte (0) sizing.
// - word load or set-width sets descriptor; byte load or clear-width clears.
// - next instruction already sees a changed width descriptor.
// - negative flag bit 11 follows result msb.
// - overflow bit 9 on signed range overflow, byte or word.
// - interrupt pushes status word; a maskable one then clears global enable bit 8.
// - global enable change acts from the next instruction.
// - bits 10,6,3,7,5,4 are plain user storage flags.
// - pointer set select bits 2..0 pick set base 0200H+8n.
// - status word saved on interrupt, restored by return from interrupt.
// - status word accessible as word, high byte or low byte.
// - program counter advances by instruction length, wraps inside segment.
// - reset or interrupt loads program counter from vector.
// - local address is 0200H + window byte*8 + register index.
// - page byte gives current page; short bit area xxC0H..xxFFH.
// - window and page bytes at 02H and 03H, undefined after reset.
// - stack accesses are words with lsb forced zero; pointer auto-adjusts.
// - stack pointer at 00H, FFFFH after any reset.
`ifndef CCR_REGS_VH
`define CCR_REGS_VH
`define CCR_SP_OFS     8'h00
`define CCR_WIN_OFS    8'h02
`define CCR_PAGE_OFS   8'h03
`define CCR_SW_LO_OFS  8'h04
`define CCR_SW_HI_OFS  8'h05
`define CCR_SP_RST     16'hFFFF
`define CCR_SW_RST     16'h0000
`define CCR_BIT_CY     15
`define CCR_BIT_ZF     14
`define CCR_BIT_HC     13
`define CCR_BIT_DD     12
`define CCR_BIT_NEG    11
`define CCR_BIT_OV     9
`define CCR_BIT_IE     8
`define CCR_LOCAL_BASE 16'h0200
`define CCR_PSET_BASE  16'h0200
`define CCR_SBA_OFS    8'hC0
`endif

// ### verilog/ccr_flag_calc.v
// arithmetic flag evaluation for byte or word results
`timescale 1ns/1ps
`default_nettype none
module ccr_flag_calc (
   input  wire        op_word,
   input  wire        op_sub,
   input  wire [15:0] opnd_a,
   input  wire [15:0] opnd_b,
   output wire [15:0] result,
   output wire        carry,
   output wire        half,
   output wire        zero,
   output wire        neg,
   output wire        ovf
);
   wire [15:0] b_eff;
   wire [16:0] sum;
   wire [4:0]  nib;
   wire [8:0]  low;
   wire        sa;
   wire        sb;
   wire        sr;
   assign b_eff  = op_sub ? ~opnd_b : opnd_b;
   assign sum    = {1'b0, opnd_a} + {1'b0, b_eff} + {16'h0000, op_sub};
   assign nib    = {1'b0, opnd_a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, op_sub};
   assign low    = {1'b0, opnd_a[7:0]} + {1'b0, b_eff[7:0]} + {8'h00, op_sub};
   assign result = op_word ? sum[15:0] : {8'h00, sum[7:0]};
   // borrow is the inverted carry when subtracting
   assign carry  = (op_word ? sum[16] : low[8]) ^ op_sub;
   assign half   = nib[4] ^ op_sub;
   assign zero   = op_word ? (sum[15:0] == 16'h0000) : (sum[7:0] == 8'h00);
   assign sa     = op_word ? opnd_a[15] : opnd_a[7];
   assign sb     = op_word ? b_eff[15] : b_eff[7];
   assign sr     = op_word ? sum[15] : sum[7];
   assign neg    = sr;
   assign ovf    = (sa == sb) && (sr != sa);
endmodule
`default_nettype wire

// ### verilog/ccr_stack_ptr.v
// stack pointer with automatic adjust and word-aligned stack address
`timescale 1ns/1ps
`default_nettype none
`include "ccr_regs.vh"
module ccr_stack_ptr (
   input  wire        clk_sys,
   input  wire        rst,
   input  wire        push,
   input  wire        pop,
   input  wire        wr_lo,
   input  wire        wr_hi,
   input  wire [15:0] wr_data,
   output reg  [15:0] sp,
   output reg  [15:0] stack_addr
);
   reg [15:0] next_sp;
   always @* begin
      next_sp = sp;
      // pointer steps by two and keeps its odd bit; only the bus address is forced even
      if (push)
         next_sp = sp - 16'h0002;
      else if (pop)
         next_sp = sp + 16'h0002;
      if (wr_lo)
         next_sp = {next_sp[15:8], wr_data[7:0]};
      if (wr_hi)
         next_sp = {wr_data[15:8], next_sp[7:0]};
   end
   always @(posedge clk_sys) begin
      if (rst) begin
         sp         <= `CCR_SP_RST;
         stack_addr <= 16'hFFFE;
      end else begin
         sp         <= next_sp;
         // word address of the slot after this update
         stack_addr <= {next_sp[15:1], 1'b0};
      end
   end
endmodule
`default_nettype wire

// ### sim/ccr_ctrl_chk.sv
// assertion checker for the cpu control register group
`timescale 1ns/1ps
`default_nettype none
module ccr_chk (
   input wire logic        clk_sys,
   input wire logic        rst,
   input wire logic        reset_event,
   input wire logic        irq_enter,
   input wire logic        irq_maskable,
   input wire logic [15:0] vector_val,
   input wire logic        instr_done,
   input wire logic [2:0]  instr_len,
   input wire logic        pc_load,
   input wire logic        return_from_interrupt,
   input wire logic        sfr_wr,
   input wire logic        sfr_word,
   input wire logic [7:0]  sfr_addr,
   input wire logic [15:0] sfr_wdata,
   input wire logic [15:0] status_word,
   input wire logic [15:0] pc,
   input wire logic [15:0] push_data,
   input wire logic [15:0] stack_addr,
   input wire logic [15:0] pointer_set_addr
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   // competing sequencer events have their own priority, so keep them out
   wire quiet = !reset_event && !irq_enter && !return_from_interrupt;
   ev_clear_a: assert property (reset_event |=> status_word == 16'h0000)
      else $error("status word kept after reset event");
   irq_mask_a: assert property (irq_enter && irq_maskable && !reset_event |=> !status_word[8])
      else $error("interrupt enable left set");
   irq_save_a: assert property (irq_enter && !reset_event |=> push_data == $past(status_word))
      else $error("saved status word wrong");
   irq_vec_a: assert property (irq_enter && !reset_event |=> pc == $past(vector_val))
      else $error("pc not loaded from vector");
   pc_step_a: assert property (instr_done && !pc_load && quiet |=> pc == 16'($past(pc) + $past(instr_len)))
      else $error("pc advance wrong");
   stack_even_a: assert property (stack_addr[0] == 1'b0)
      else $error("odd stack address");
   sw_write_a: assert property (sfr_wr && sfr_word && sfr_addr == 8'h04 && quiet |=> status_word == $past(sfr_wdata))
      else $error("status word write lost");
   pset_map_a: assert property (!$past(rst) && $stable(status_word) |->
      pointer_set_addr == 16'h0200 + {10'h000, status_word[2:0], 3'h0})
      else $error("pointer set address wrong");
endmodule
bind ccr_ctrl ccr_chk ccr_chk_i (.*);
`default_nettype wire

// ### sim/ccr_cpu_model.sv
// far-side model: vector source and stack store for the status word
`timescale 1ns/1ps
`default_nettype none
module ccr_cpu_model #(
   parameter [15:0] VEC = 16'h0040
) (
   input  wire logic        clk_sys,
   input  wire logic        irq_enter,
   input  wire logic [15:0] push_data,
   output wire logic [15:0] vector_val,
   output var  logic [15:0] restore_sw
);
   logic irq_d = 1'b0;
   assign vector_val = VEC;
   initial restore_sw = 16'h0000;
   // the pushed word is valid one cycle after the transition
   always @(posedge clk_sys) begin
      irq_d <= irq_enter;
      if (irq_d) begin
         restore_sw <= push_data;
      end
   end
endmodule
`default_nettype wire

// ### sim/ccr_ctrl_test.sv
// self-checking bench for the cpu control register group
`timescale 1ns/1ps
`default_nettype none
module ccr_ctrl_test;
   logic clk_sys, rst, reset_event, alu_valid, alu_is_logic, alu_sub, acc_load, acc_load_word, bit_test, bit_value;
   logic set_width_op, clear_width_op, carry_wr, carry_val, instr_done, pc_load, irq_enter, irq_maskable;
   logic return_from_interrupt, stack_push, stack_pop, sfr_wr, sfr_word, sfr_rd, sfr_hit, global_irq_enable;
   logic width_descriptor;
   logic [2:0] instr_len, local_index;
   logic [5:0] sba_offset;
   logic [7:0] sfr_addr;
   logic [15:0] alu_a, alu_b, acc_load_data, pc_load_val, vector_val, restore_sw, sfr_wdata, sfr_rdata, status_word;
   logic [15:0] pc, hw_stack_pointer, stack_addr, push_data, local_addr, page_bit_addr, pointer_set_addr, acc_result;
   int errors, num_checks, cyc, i;
   ccr_ctrl ccr_ctrl_i (.*);
   ccr_cpu_model ccr_cpu_model_i (.*);
   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         errors = errors + 1;
         test_done;
      end
   end
   // ==========================================
   // access tasks
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
      num_checks++;
      if (g !== e) begin
         errors++;
         $display("mismatch %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic sfr_write(input logic [7:0] a, input logic w, input logic [15:0] d);
      {sfr_addr, sfr_word, sfr_wdata, sfr_wr} = {a, w, d, 1'b1};
      tick(1);
      sfr_wr = 1'b0;
      tick(1);
   endtask
   task automatic sfr_read(input logic [7:0] a, input logic [15:0] e);
      {sfr_addr, sfr_word, sfr_rd} = {a, 2'b11};
      tick(1);
      chk("sfr read", e, sfr_rdata);
      chk("sfr hit", {15'h0000, a < 8'h06}, {15'h0000, sfr_hit});
      sfr_rd = 1'b0;
      tick(1);
   endtask
   // width op rides in the same cycle, so the flags must already use it
   task automatic alu(input logic w, input logic s, input logic [15:0] a, input logic [15:0] b, input logic [15:0] e);
      {set_width_op, clear_width_op, alu_sub, alu_a, alu_b, alu_valid} = {w, !w, s, a, b, 1'b1};
      tick(1);
      {set_width_op, clear_width_op, alu_valid} = 3'b000;
      tick(1);
      chk("flags", e, status_word & 16'hFA00);
   endtask
   task automatic test_done;
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   initial begin
      {reset_event, alu_valid, alu_is_logic, alu_sub, acc_load, acc_load_word, bit_test, bit_value} = 8'h00;
      {set_width_op, clear_width_op, carry_wr, carry_val, instr_done, pc_load, irq_enter, irq_maskable} = 8'h00;
      {return_from_interrupt, stack_push, stack_pop, sfr_wr, sfr_word, sfr_rd, instr_len} = 9'h000;
      {local_index, sba_offset, sfr_addr, alu_a, alu_b, acc_load_data, pc_load_val, sfr_wdata} = 97'h0;
      rst = 1'b1;
      tick(10);
      rst = 1'b0;
      tick(1);
      chk("status", 16'h0000, status_word);
      chk("sp", 16'hFFFF, hw_stack_pointer);
      chk("pc", 16'h0040, pc);
      sfr_read(8'h00, 16'hFFFF);
      sfr_write(8'h04, 1'b1, 16'h1234);
      chk("status", 16'h1234, status_word);
      sfr_write(8'h05, 1'b0, 16'hA5A5);
      sfr_read(8'h04, 16'hA534);
      sfr_write(8'h04, 1'b1, 16'h04F8);
      chk("status", 16'h04F8, status_word);
      for (i = 0; i < 8; i++) begin
         sfr_write(8'h04, 1'b0, {2{5'h1F, i[2:0]}});
         chk("status", {8'h04, 5'h1F, i[2:0]}, status_word);
         chk("pointer set", 16'h0200 + {10'h000, i[2:0], 3'h0}, pointer_set_addr);
      end
      {local_index, sba_offset} = {3'h7, 6'h05};
      sfr_write(8'h02, 1'b0, 16'hFFFF);
      sfr_write(8'h03, 1'b0, 16'h1212);
      chk("local", 16'h09FF, local_addr);
      chk("page bit", 16'h12C5, page_bit_addr);
      sfr_read(8'h02, 16'h12FF);
      sfr_read(8'h40, 16'h0000);
      alu(1'b1, 1'b0, 16'h7FFF, 16'h0001, 16'h3A00);
      chk("acc", 16'h8000, acc_result);
      alu(1'b0, 1'b0, 16'h00FF, 16'h0001, 16'hE000);
      chk("acc", 16'h0000, acc_result);
      alu(1'b1, 1'b1, 16'h0000, 16'h0001, 16'hB800);
      alu(1'b0, 1'b1, 16'h0080, 16'h0001, 16'h2200);
      {acc_load, acc_load_word, acc_load_data} = {2'b11, 16'h0000};
      tick(1);
      acc_load = 1'b0;
      tick(1);
      chk("load flags", 16'h5000, status_word & 16'h5000);
      chk("width", 16'h0001, {15'h0000, width_descriptor});
      {bit_test, bit_value, carry_wr, carry_val} = 4'b1011;
      tick(1);
      {bit_test, carry_wr} = 2'b00;
      tick(1);
      chk("bit flags", 16'hC000, status_word & 16'hC000);
      {alu_is_logic, alu_a, alu_valid} = {1'b1, 16'h8000, 1'b1};
      tick(1);
      {alu_is_logic, alu_valid} = 2'b00;
      tick(1);
      chk("logic flags", 16'h8800, status_word & 16'hC800);
      sfr_write(8'h04, 1'b1, 16'h0100);
      {irq_enter, irq_maskable} = 2'b11;
      tick(1);
      irq_enter = 1'b0;
      tick(2);
      chk("ie", 16'h0000, {15'h0000, global_irq_enable});
      chk("push", 16'h0100, push_data);
      chk("sp", 16'hFFFD, hw_stack_pointer);
      return_from_interrupt = 1'b1;
      tick(1);
      return_from_interrupt = 1'b0;
      tick(1);
      chk("status", 16'h0100, status_word);
      {pc_load, pc_load_val} = {1'b1, 16'hFFFE};
      tick(1);
      {pc_load, instr_done, instr_len} = {2'b01, 3'h4};
      tick(1);
      instr_done = 1'b0;
      tick(1);
      chk("pc", 16'h0002, pc);
      reset_event = 1'b1;
      tick(1);
      reset_event = 1'b0;
      tick(2);
      chk("status", 16'h0000, status_word);
      chk("sp", 16'hFFFF, hw_stack_pointer);
      stack_push = 1'b1;
      tick(1);
      stack_push = 1'b0;
      tick(2);
      chk("sp", 16'hFFFD, hw_stack_pointer);
      chk("stack addr", 16'hFFFC, stack_addr);
      stack_pop = 1'b1;
      tick(1);
      stack_pop = 1'b0;
      tick(2);
      chk("sp", 16'hFFFF, hw_stack_pointer);
      sfr_write(8'h00, 1'b1, 16'h1234);
      sfr_read(8'h00, 16'h1234);
      test_done;
   end
endmodule
`default_nettype wire
